// ### design/rcms_sequencer.sv
// Decided for this implementation: register access over AXI4-Lite and the address map.
module rcms_sequencer #(
   parameter int unsigned SUPPLY_BLANK = rcms_pkg::SUPPLY_BLANK_CYC,
   parameter int unsigned PROT_BLANK = rcms_pkg::PROT_BLANK_CYC,
   parameter int unsigned REMOTE_HOLD = rcms_pkg::REMOTE_HOLD_CYC
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [rcms_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [rcms_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Comparators and block controls
   input wire rcms_pkg::rcms_cmp_t cmp_i,
   output rcms_pkg::rcms_out_t ctl_o,
   output logic irq_o
);
   import rcms_pkg::*;

   rcms_st_t q;
   rcms_st_t d;
   rcms_cmp_t c;
   logic son_rise;
   logic fault;
   logic [3:0] clr;
   logic [3:0] ev;
   logic full_on;

   assign c = rcms_cmp_t'(q.cln);
   assign son_rise = c.supply_on & ~q.son_prev;
   // Latch input masked while its own blank runs
   assign fault = (c.latch_fault & (q.prot_cnt == '0)) | ~c.line_ok;

   always_comb begin
      d = q;
      clr = 4'h0;
      ev = 4'h0;
      full_on = 1'b0;
      // Three-stage input capture
      d.s1 = cmp_i;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.cln = (q.s2 & q.s3) | (q.cln & (q.s2 ^ q.s3));
      d.son_prev = c.supply_on;
      if (q.blank_cnt != '0) begin
         d.blank_cnt = q.blank_cnt - 1'b1;
      end
      if (q.prot_cnt != '0) begin
         d.prot_cnt = q.prot_cnt - 1'b1;
      end
      if (q.rem_cnt != '0) begin
         d.rem_cnt = q.rem_cnt - 1'b1;
      end
      // Write channel
      if (s_axi_awvalid && q.awready) begin
         d.awaddr = s_axi_awaddr;
         d.awready = 1'b0;
      end
      if (s_axi_wvalid && q.wready) begin
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
         d.wready = 1'b0;
      end
      if (!q.awready && !q.wready && !q.bvalid) begin
         d.bvalid = 1'b1;
         d.bresp = RESP_OKAY;
         case (q.awaddr)
            OFS_CTRL: begin
               if (q.wstrb[0]) begin
                  d.variant = q.wdata[CTRL_VARIANT_BIT];
               end
            end
            OFS_STATUS: begin
               d.bresp = RESP_OKAY;
            end
            OFS_IRQ_STAT: begin
               if (q.wstrb[0]) begin
                  clr = q.wdata[3:0];
               end
            end
            OFS_IRQ_MASK: begin
               if (q.wstrb[0]) begin
                  d.irq_mask = q.wdata[3:0];
               end
            end
            default: begin
               d.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
         d.awready = 1'b1;
         d.wready = 1'b1;
      end
      // Read channel
      if (s_axi_arvalid && q.arready) begin
         d.arready = 1'b0;
         d.rvalid = 1'b1;
         d.rresp = RESP_OKAY;
         d.rdata = 32'h0;
         case (s_axi_araddr)
            OFS_CTRL: begin
               d.rdata[CTRL_VARIANT_BIT] = q.variant;
            end
            OFS_STATUS: begin
               d.rdata[STAT_ST_LSB +: 3] = q.st;
               d.rdata[STAT_CMP_LSB +: 8] = q.cln;
               d.rdata[STAT_OUT_LSB +: 12] = q.out;
            end
            OFS_IRQ_STAT: begin
               d.rdata[3:0] = q.irq_stat;
            end
            OFS_IRQ_MASK: begin
               d.rdata[3:0] = q.irq_mask;
            end
            default: begin
               d.rresp = RESP_SLVERR;
            end
         endcase
      end
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
         d.arready = 1'b1;
      end
      // Sequencer
      case (q.st)
         ST_CHARGE: begin
            if (son_rise) begin
               d.st = ST_BLANK;
               d.blank_cnt = CNT_W'(SUPPLY_BLANK);
               d.prot_cnt = CNT_W'(PROT_BLANK);
               d.rem_cnt = CNT_W'(REMOTE_HOLD);
            end
         end
         ST_BLANK: begin
            if (c.supply_off) begin
               d.st = ST_CHARGE;
            end else if (q.blank_cnt == '0) begin
               if (fault) begin
                  d.st = ST_CHARGE;
                  ev[IRQ_FAULT] = 1'b1;
               end else begin
                  d.st = ST_RUN;
                  ev[IRQ_RUN] = 1'b1;
               end
            end
         end
         ST_RUN: begin
            if (!q.variant && c.remote_off && q.rem_cnt == '0) begin
               d.st = ST_OFF;
               ev[IRQ_OFF] = 1'b1;
            end else if (q.variant && c.fb_off) begin
               d.st = ST_PSKIP;
               ev[IRQ_SKIP] = 1'b1;
            end else if (c.supply_off) begin
               d.st = ST_CHARGE;
            end else if (c.skip_in) begin
               d.st = ST_SKIP;
               ev[IRQ_SKIP] = 1'b1;
            end
         end
         ST_SKIP: begin
            if (!q.variant && c.remote_off && q.rem_cnt == '0) begin
               d.st = ST_OFF;
               ev[IRQ_OFF] = 1'b1;
            end else if (c.supply_off) begin
               d.st = q.variant ? ST_OFF : ST_CHARGE;
            end else if (q.variant && c.fb_off) begin
               d.st = ST_PSKIP;
            end else if (!c.skip_in) begin
               d.st = ST_RUN;
               d.prot_cnt = CNT_W'(PROT_BLANK);
            end
         end
         ST_PSKIP: begin
            if (c.supply_off) begin
               d.st = ST_OFF;
               ev[IRQ_OFF] = 1'b1;
            end else if (!c.fb_off) begin
               d.st = ST_SKIP;
            end
         end
         ST_OFF: begin
            if (!q.variant && !c.remote_off) begin
               d.st = ST_CHARGE;
            end else if (q.variant && !c.fb_off) begin
               d.st = ST_CHARGE;
            end
         end
         default: begin
            d.st = ST_CHARGE;
         end
      endcase
      // Block controls follow the next state
      full_on = (d.st == ST_BLANK) || (d.st == ST_RUN);
      d.out.line_monitor_en = full_on || (d.st == ST_CHARGE) || (d.st == ST_PSKIP);
      d.out.feedback_en = (d.st != ST_OFF);
      d.out.latch_prot_en = full_on;
      d.out.front_stage_en = full_on;
      d.out.front_stage_mode_high = full_on && !c.fb_below_front;
      d.out.gate_drivers_en = (d.st == ST_RUN);
      d.out.seq_start = (q.st == ST_BLANK) && (d.st == ST_RUN);
      d.out.remote_pin_o = 1'b0;
      d.out.remote_pin_oe = (d.rem_cnt != '0);
      d.out.startup_src_en = (d.st == ST_CHARGE) || (d.st == ST_OFF);
      d.out.dss_en = (d.st == ST_OFF);
      d.out.supply_mgmt_full = (d.st != ST_OFF);
      // Set beats clear
      d.irq_stat = (q.irq_stat & ~clr) | ev;
      d.irq = |(d.irq_stat & d.irq_mask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= ST_RST;
      end else begin
         q <= d;
      end
   end

   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rresp = q.rresp;
   assign s_axi_rdata = q.rdata;
   assign ctl_o = q.out;
   assign irq_o = q.irq;

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_blank_start;
      q.st == ST_CHARGE && son_rise |=> q.st == ST_BLANK && q.blank_cnt == CNT_W'(SUPPLY_BLANK)
         && q.prot_cnt == CNT_W'(PROT_BLANK) && q.rem_cnt == CNT_W'(REMOTE_HOLD);
   endproperty
   a_blank_start: assert property (p_blank_start) else $error("blanks not started together");

   property p_run_start;
      q.st == ST_BLANK && q.blank_cnt == '0 && !fault && !c.supply_off
         |=> q.st == ST_RUN && q.out.seq_start ##1 !q.out.seq_start;
   endproperty
   a_run_start: assert property (p_run_start) else $error("startup sequence not launched");

   property p_blocks_on;
      q.st == ST_BLANK |-> q.out.line_monitor_en && q.out.feedback_en && q.out.latch_prot_en
         && q.out.front_stage_en;
   endproperty
   a_blocks_on: assert property (p_blocks_on) else $error("blocks not enabled after supply-on");

   property p_hold;
      $rose(q.out.remote_pin_oe) |-> q.rem_cnt == CNT_W'(REMOTE_HOLD) && !q.out.remote_pin_o;
   endproperty
   a_hold: assert property (p_hold) else $error("remote hold not applied");

   property p_no_drv_blank;
      q.st == ST_BLANK && q.blank_cnt != '0 && !c.supply_off |=> q.st == ST_BLANK && !q.out.gate_drivers_en;
   endproperty
   a_no_drv_blank: assert property (p_no_drv_blank) else $error("fault acted during blank");

   property p_drv_on;
      q.st == ST_BLANK && q.blank_cnt == '0 && !fault && !c.supply_off |=> q.out.gate_drivers_en;
   endproperty
   a_drv_on: assert property (p_drv_on) else $error("drivers delayed after blank");

   property p_front_off;
      c.fb_below_front |=> !q.out.front_stage_mode_high;
   endproperty
   a_front_off: assert property (p_front_off) else $error("front-stage output not lowered");

   property p_remote_off;
      !q.variant && (q.st == ST_RUN || q.st == ST_SKIP) && c.remote_off && q.rem_cnt == '0
         |=> q.st == ST_OFF && !q.out.feedback_en && !q.out.gate_drivers_en;
   endproperty
   a_remote_off: assert property (p_remote_off) else $error("remote-off ignored");

   property p_dss;
      q.st == ST_OFF |-> q.out.dss_en && !q.out.supply_mgmt_full;
   endproperty
   a_dss: assert property (p_dss) else $error("self-supply missing in off-mode");

   property p_off_exit;
      q.st == ST_OFF && ((!q.variant && !c.remote_off) || (q.variant && !c.fb_off))
         |=> q.st == ST_CHARGE && q.out.startup_src_en && !q.out.dss_en;
   endproperty
   a_off_exit: assert property (p_off_exit) else $error("off-mode exit failed");

   property p_skip;
      q.st == ST_SKIP && !c.skip_in && !c.supply_off && !c.remote_off && !c.fb_off
         |=> q.out.gate_drivers_en && q.prot_cnt == CNT_W'(PROT_BLANK);
   endproperty
   a_skip: assert property (p_skip) else $error("skip burst not restarted");

   property p_pskip;
      q.st == ST_PSKIP |-> !q.out.gate_drivers_en && q.out.feedback_en && q.out.line_monitor_en
         && !q.out.latch_prot_en;
   endproperty
   a_pskip: assert property (p_pskip) else $error("prolonged skip blocks wrong");

   property p_pskip_off;
      q.st == ST_PSKIP && c.supply_off |=> q.st == ST_OFF && !q.out.feedback_en;
   endproperty
   a_pskip_off: assert property (p_pskip_off) else $error("off-mode not confirmed");

   property p_wait_son;
      q.st == ST_CHARGE && !son_rise |=> q.st == ST_CHARGE;
   endproperty
   a_wait_son: assert property (p_wait_son) else $error("start without supply-on");

   property p_skip_blocks;
      q.st == ST_SKIP |-> q.out.feedback_en && q.out.supply_mgmt_full && !q.out.line_monitor_en
         && !q.out.latch_prot_en && !q.out.gate_drivers_en;
   endproperty
   a_skip_blocks: assert property (p_skip_blocks) else $error("skip blocks wrong");

   property p_skip_vcc;
      !q.variant && q.st == ST_SKIP && c.supply_off && !(c.remote_off && q.rem_cnt == '0)
         |=> q.st == ST_CHARGE;
   endproperty
   a_skip_vcc: assert property (p_skip_vcc) else $error("no restart on supply loss");

   property p_sync;
      ((q.cln ^ $past(q.cln)) & ($past(q.s2) ^ $past(q.s3))) == 8'h00
         && ((q.cln ^ $past(q.cln)) & (q.cln ^ $past(q.s2))) == 8'h00;
   endproperty
   a_sync: assert property (p_sync) else $error("input changed before agreement");

   property p_fault_irq;
      q.st == ST_BLANK && q.blank_cnt == '0 && fault && !c.supply_off
         |=> q.st == ST_CHARGE && q.irq_stat[IRQ_FAULT] && !q.out.gate_drivers_en;
   endproperty
   a_fault_irq: assert property (p_fault_irq) else $error("fault at blank end not handled");

   property p_drv_state;
      q.out.gate_drivers_en |-> q.st == ST_RUN && q.out.supply_mgmt_full && !q.out.dss_en;
   endproperty
   a_drv_state: assert property (p_drv_state) else $error("drivers on outside run");

endmodule // rcms_sequencer

// ### design/rcms_pkg.sv
package rcms_pkg;
   // Timing base
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned SUPPLY_BLANK_NS = 20000;
   localparam int unsigned PROT_BLANK_NS = 10000;
   localparam int unsigned REMOTE_HOLD_NS = 40000;
   localparam int unsigned SUPPLY_BLANK_CYC = (SUPPLY_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PROT_BLANK_CYC = (PROT_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned REMOTE_HOLD_CYC = (REMOTE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 16;
   // Register map
   localparam int unsigned AXI_AW = 8;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int unsigned CTRL_VARIANT_BIT = 0;
   localparam int unsigned STAT_ST_LSB = 0;
   localparam int unsigned STAT_CMP_LSB = 8;
   localparam int unsigned STAT_OUT_LSB = 16;
   localparam int unsigned IRQ_RUN = 0;
   localparam int unsigned IRQ_SKIP = 1;
   localparam int unsigned IRQ_OFF = 2;
   localparam int unsigned IRQ_FAULT = 3;
   localparam logic [3:0] IRQ_RST = 4'h0;
   localparam logic VARIANT_RST = 1'b0;
   typedef enum logic [2:0] {ST_CHARGE, ST_BLANK, ST_RUN, ST_SKIP, ST_PSKIP, ST_OFF} rcms_state_t;
   // Comparator inputs
   typedef struct packed {
      logic latch_fault;
      logic fb_below_front;
      logic fb_off;
      logic line_ok;
      logic skip_in;
      logic remote_off;
      logic supply_off;
      logic supply_on;
   } rcms_cmp_t;
   // Block controls
   typedef struct packed {
      logic supply_mgmt_full;
      logic dss_en;
      logic startup_src_en;
      logic remote_pin_oe;
      logic remote_pin_o;
      logic seq_start;
      logic gate_drivers_en;
      logic front_stage_mode_high;
      logic front_stage_en;
      logic latch_prot_en;
      logic feedback_en;
      logic line_monitor_en;
   } rcms_out_t;
   typedef struct packed {
      rcms_state_t st;
      logic [7:0] s1;
      logic [7:0] s2;
      logic [7:0] s3;
      logic [7:0] cln;
      logic son_prev;
      logic [CNT_W-1:0] blank_cnt;
      logic [CNT_W-1:0] prot_cnt;
      logic [CNT_W-1:0] rem_cnt;
      logic variant;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
      logic irq;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      rcms_out_t out;
   } rcms_st_t;
   localparam rcms_st_t ST_RST = '{st: ST_CHARGE, awready: 1'b1, wready: 1'b1, arready: 1'b1,
                                   variant: VARIANT_RST, irq_stat: IRQ_RST, irq_mask: IRQ_RST,
                                   out: '{startup_src_en: 1'b1, supply_mgmt_full: 1'b1, default: 1'b0},
                                   default: '0};
endpackage

// ### dv/rcms_secondary.sv
module rcms_secondary (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Commands from the bench
   input wire logic want_off,
   input wire logic fb_variant,
   input wire logic [2:0] lat,
   // Device side
   input wire logic remote_pin_oe,
   output logic remote_off,
   output logic fb_off
);
   timeunit 1ns;
   timeprecision 1ns;
   logic rel_q;
   logic [2:0] cnt_q;
   // Optocoupler follows the command lat+1 cycles after it changes
   always @(posedge aclk) begin
      if (!aresetn) begin
         rel_q <= 1'b0;
         cnt_q <= 3'h0;
      end else if (want_off != rel_q && cnt_q >= lat) begin
         rel_q <= want_off;
         cnt_q <= 3'h0;
      end else if (want_off != rel_q) begin
         cnt_q <= cnt_q + 3'h1;
      end else begin
         cnt_q <= 3'h0;
      end
   end
   // Pulled-up pin: high only when nobody pulls it low
   assign remote_off = !remote_pin_oe && rel_q && !fb_variant;
   // Released opto lets the pull-up raise feedback
   assign fb_off = rel_q && fb_variant;
endmodule // rcms_secondary

// ### dv/resonant_ctrl_mode_sequencer_bench.sv
module resonant_ctrl_mode_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import rcms_pkg::*;
   localparam int unsigned SB = 8;
   localparam int unsigned PB = 4;
   localparam int unsigned RH = 16;
   typedef struct packed {
      logic v;
      logic [7:0] c;
      logic off;
      logic [2:0] st;
      logic g;
      logic dynamic_self_supply;
      logic fsm;
   } rcms_row_t;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, cmp_b = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq_o, remote_off, fb_off;
   logic [1:0] bresp, rresp;
   logic want_off = 1'b0, fb_var = 1'b0;
   logic [2:0] lat = 3'h0;
   rcms_cmp_t cmp_w;
   rcms_out_t ctl;
   int mismatches = 0, cmp_count = 0, oe_n, sq_n;
   // Rows: variant, comparators, off request, state, drivers, self-supply, front-stage level
   rcms_row_t rows [18] = '{
      '{0, 8'h10, 0, 0, 0, 0, 0},
      '{0, 8'h11, 0, 2, 1, 0, 1},
      '{0, 8'h51, 0, 2, 1, 0, 0},
      '{0, 8'h19, 0, 3, 0, 0, 0},
      '{0, 8'h11, 0, 2, 1, 0, 1},
      '{0, 8'h19, 0, 3, 0, 0, 0},
      '{0, 8'h1a, 0, 0, 0, 0, 0},
      '{0, 8'h19, 0, 3, 0, 0, 0},
      '{0, 8'h19, 1, 5, 0, 1, 0},
      '{0, 8'h10, 0, 0, 0, 0, 0},
      '{0, 8'h11, 0, 2, 1, 0, 1},
      '{0, 8'h11, 1, 5, 0, 1, 0},
      '{0, 8'h10, 0, 0, 0, 0, 0},
      '{1, 8'h11, 0, 2, 1, 0, 1},
      '{1, 8'h11, 1, 4, 0, 0, 0},
      '{1, 8'h13, 1, 5, 0, 1, 0},
      '{1, 8'h10, 0, 0, 0, 0, 0},
      '{1, 8'h11, 0, 2, 1, 0, 1}};
   assign cmp_w = {cmp_b[7:6], fb_off, cmp_b[4:3], remote_off, cmp_b[1:0]};
   rcms_sequencer #(.SUPPLY_BLANK(SB), .PROT_BLANK(PB), .REMOTE_HOLD(RH)) dut_u (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .cmp_i(cmp_w), .ctl_o(ctl), .irq_o(irq_o));
   rcms_secondary sec_u (
      .aclk(aclk), .aresetn(aresetn), .want_off(want_off), .fb_variant(fb_var), .lat(lat),
      .remote_pin_oe(ctl.remote_pin_oe), .remote_off(remote_off), .fb_off(fb_off));
   initial begin
      forever #50 aclk = ~aclk;
   end
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic wt(input int n);
      oe_n = 0;
      sq_n = 0;
      repeat (n) begin
         @(posedge aclk);
         oe_n += int'(ctl.remote_pin_oe);
         sq_n += int'(ctl.seq_start);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int k;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 60; k++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
      if (k == 60) begin
         mismatches++;
         conclude();
      end
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 60; k++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
      if (k == 60) begin
         mismatches++;
         conclude();
      end
      @(posedge aclk);
   endtask
   initial begin
      logic [31:0] d;
      logic [1:0] rs;
      logic [3:0] blk;
      rcms_row_t r;
      repeat (4) @(posedge aclk);
      chk("ctl_reset", 32'ha00, ctl);
      chk("irq_reset", 32'h0, irq_o);
      aresetn <= 1'b1;
      @(posedge aclk);
      $display("test reset done");
      foreach (rows[i]) begin
         r = rows[i];
         wr(OFS_CTRL, {31'h0, r.v}, rs);
         cmp_b <= r.c;
         want_off <= r.off;
         fb_var <= r.v;
         wt(30);
         rd(OFS_STATUS, d, rs);
         chk("state", r.st, d[2:0]);
         chk("gate", r.g, ctl.gate_drivers_en);
         chk("dss", r.dynamic_self_supply, ctl.dss_en);
         chk("front_mode", r.fsm, ctl.front_stage_mode_high);
         if (r.st == 3'h2) begin
            blk = {ctl.feedback_en, ctl.line_monitor_en, ctl.latch_prot_en, ctl.front_stage_en};
            chk("run_blocks", 32'hf, blk);
         end
         if (r.st == 3'h3) begin
            blk = {ctl.feedback_en, ctl.line_monitor_en, ctl.latch_prot_en, ctl.gate_drivers_en};
            chk("skip_blocks", 32'h8, blk);
         end
         if (r.st == 3'h5) begin
            blk = {ctl.feedback_en, ctl.supply_mgmt_full, ctl.dss_en, ctl.startup_src_en};
            chk("off_blocks", 32'h3, blk);
         end
      end
      $display("test sequence rows done");
      rd(OFS_IRQ_STAT, d, rs);
      chk("irq_stat", 32'h7, d);
      chk("irq_masked", 32'h0, irq_o);
      wr(OFS_IRQ_MASK, 32'h4, rs);
      wt(3);
      chk("irq_on", 32'h1, irq_o);
      wr(OFS_IRQ_STAT, 32'h4, rs);
      wt(3);
      chk("irq_off", 32'h0, irq_o);
      rd(OFS_IRQ_STAT, d, rs);
      chk("irq_w1c", 32'h3, d);
      rd(8'h10, d, rs);
      chk("unmapped_rresp", RESP_SLVERR, rs);
      chk("unmapped_rdata", 32'h0, d);
      wr(8'h10, 32'h1, rs);
      chk("unmapped_bresp", RESP_SLVERR, rs);
      wr(OFS_STATUS, 32'h7, rs);
      chk("status_write", RESP_OKAY, rs);
      wr(OFS_IRQ_STAT, 32'hf, rs);
      wr(OFS_IRQ_MASK, 32'h8, rs);
      $display("test registers done");
      cmp_b <= 8'h12;
      wt(20);
      wr(OFS_CTRL, 32'h0, rs);
      fb_var <= 1'b0;
      want_off <= 1'b1;
      lat <= 3'h3;
      cmp_b <= 8'h11;
      wt(40);
      chk("hold_cycles", RH, oe_n);
      chk("remote_low", 32'h0, ctl.remote_pin_o);
      rd(OFS_STATUS, d, rs);
      chk("off_after_hold", 32'h5, d[2:0]);
      want_off <= 1'b0;
      lat <= 3'h0;
      cmp_b <= 8'h10;
      wt(30);
      $display("test remote hold done");
      cmp_b <= 8'h91;
      wt(30);
      rd(OFS_STATUS, d, rs);
      chk("fault_state", 32'h0, d[2:0]);
      chk("fault_gate", 32'h0, ctl.gate_drivers_en);
      chk("fault_irq", 32'h1, irq_o);
      cmp_b <= 8'h10;
      wt(10);
      cmp_b <= 8'h01;
      wt(6);
      cmp_b <= 8'h11;
      wt(30);
      rd(OFS_STATUS, d, rs);
      chk("blank_ignore", 32'h2, d[2:0]);
      chk("seq_pulse", 32'h1, sq_n);
      $display("test blanking done");
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      chk("ctl_midrun_reset", 32'ha00, ctl);
      chk("irq_midrun_reset", 32'h0, irq_o);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(OFS_STATUS, d, rs);
      chk("state_after_reset", 32'h0, d[2:0]);
      rd(OFS_IRQ_MASK, d, rs);
      chk("mask_after_reset", 32'h0, d);
      wt(30);
      rd(OFS_STATUS, d, rs);
      chk("restart_after_reset", 32'h2, d[2:0]);
      chk("restart_pulse", 32'h1, sq_n);
      $display("test midrun reset done");
      conclude();
   end
endmodule // resonant_ctrl_mode_sequencer_bench
